// File: logic/typeb_contactless_framer.sv
// Bit-level Type B framer: deframes reader frames into a buffer, frames device answers.
// Assumes rx_level is the demodulated ASK level and the answer bytes come from a user stream.
`timescale 1ns/1ns
module typeb_contactless_framer #(
   parameter int FRAME_SIZE = typeb_pkg::MAX_FIELD
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       rate_212,
   input  wire logic       rx_level,
   input  wire logic [7:0] rd_addr,
   input  wire logic       tx_start,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic       tx_last,
   output logic [7:0]      rd_data,
   output logic            rx_done,
   output logic            rx_ok,
   output logic [8:0]      rx_len,
   output logic [1:0]      rx_type,
   output logic            rx_chaining,
   output logic            rx_deselect,
   output logic            tx_ready,
   output logic            tx_busy,
   output logic            tx_err,
   output logic            tx_mod
);
   initial begin
      if (FRAME_SIZE < typeb_pkg::MIN_FRAME || FRAME_SIZE > typeb_pkg::MAX_FIELD) begin
         $error("FRAME_SIZE out of range");
      end
   end

   function automatic logic [15:0] crc_b(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ typeb_pkg::CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   logic [11:0] etu;
   assign etu = rate_212 ? typeb_pkg::ETU_212 : typeb_pkg::ETU_106;

   ////////////////////////////////////////////////////////////////////////////////////
   // Receive side. The whole data field is kept so the upper layer can parse it late.
   typeb_pkg::rx_state_t rx_state, next_rx_state;
   logic [7:0]  rx_mem [typeb_pkg::MAX_FIELD];
   logic [11:0] rx_cnt, next_rx_cnt;
   logic [3:0]  rx_bitn, next_rx_bitn;
   logic [7:0]  rx_shift, next_rx_shift;
   logic [8:0]  rx_count, next_rx_count;
   logic [15:0] rx_crc, next_rx_crc;
   logic        rx_big, next_rx_big;
   logic [7:0]  rx_pcb, next_rx_pcb;
   logic        rx_we;
   logic        next_rx_done, next_rx_ok;
   logic [8:0]  next_rx_len;
   logic [1:0]  next_rx_type;
   logic        next_rx_chaining, next_rx_deselect;

   always_comb begin
      next_rx_state    = rx_state;
      next_rx_cnt      = rx_cnt;
      next_rx_bitn     = rx_bitn;
      next_rx_shift    = rx_shift;
      next_rx_count    = rx_count;
      next_rx_crc      = rx_crc;
      next_rx_big      = rx_big;
      next_rx_pcb      = rx_pcb;
      rx_we            = 1'b0;
      next_rx_done     = 1'b0;
      next_rx_ok       = rx_ok;
      next_rx_len      = rx_len;
      next_rx_type     = rx_type;
      next_rx_chaining = rx_chaining;
      next_rx_deselect = rx_deselect;
      unique case (rx_state)
         typeb_pkg::RX_IDLE: begin
            if (!rx_level) begin
               if (rx_cnt != 12'hfff) begin
                  next_rx_cnt = rx_cnt + 12'h001;
               end
            end else begin
               // A long low followed by high is the start marker.
               if (rx_cnt >= 12'(typeb_pkg::SOF_LOW_ETU * etu)) begin
                  next_rx_state = typeb_pkg::RX_WAIT;
                  next_rx_count = 9'h000;
                  next_rx_crc   = typeb_pkg::CRC_INIT;
                  next_rx_big   = 1'b0;
               end
               next_rx_cnt = 12'h000;
            end
         end
         typeb_pkg::RX_WAIT: begin
            if (!rx_level) begin
               next_rx_state = typeb_pkg::RX_BITS;
               next_rx_cnt   = etu >> 1;
               next_rx_bitn  = 4'h0;
            end
         end
         typeb_pkg::RX_BITS: begin
            if (rx_cnt != 12'h000) begin
               next_rx_cnt = rx_cnt - 12'h001;
            end else begin
               next_rx_cnt  = etu - 12'h001;
               next_rx_bitn = rx_bitn + 4'h1;
               if (rx_bitn == 4'h0) begin
                  if (rx_level) begin
                     next_rx_state = typeb_pkg::RX_IDLE; // Glitch, not a start bit.
                     next_rx_cnt   = 12'h000;
                  end
               end else if (rx_bitn != typeb_pkg::STOP_BIT) begin
                  next_rx_shift = {rx_level, rx_shift[7:1]};
               end else if (rx_level) begin
                  next_rx_state = typeb_pkg::RX_WAIT;
                  if (rx_count == 9'(FRAME_SIZE)) begin
                     next_rx_big = 1'b1;
                  end else begin
                     rx_we         = 1'b1;
                     next_rx_count = rx_count + 9'h001;
                     next_rx_crc   = crc_b(rx_crc, rx_shift);
                     if (rx_count == 9'h000) begin
                        next_rx_pcb = rx_shift;
                     end
                  end
               end else begin
                  // Low stop bit: end marker when the data bits were all low, else bad.
                  next_rx_state    = typeb_pkg::RX_IDLE;
                  next_rx_cnt      = 12'h000;
                  next_rx_done     = 1'b1;
                  next_rx_len      = rx_count;
                  next_rx_type     = rx_pcb[typeb_pkg::PCB_TYPE_HI:typeb_pkg::PCB_TYPE_LO];
                  next_rx_chaining = (next_rx_type == typeb_pkg::TYPE_I)
                                     && rx_pcb[typeb_pkg::PCB_CHAIN];
                  next_rx_deselect = (next_rx_type == typeb_pkg::TYPE_S)
                                     && (rx_pcb[typeb_pkg::PCB_SFN_HI:typeb_pkg::PCB_SFN_LO]
                                         == typeb_pkg::S_DESELECT);
                  // An identifier flag, or an address flag on an information block, marks a block this device cannot parse.
                  next_rx_ok = (rx_shift == 8'h00) && !rx_big
                               && (rx_count >= 9'(typeb_pkg::MIN_BLOCK))
                               && (rx_crc == typeb_pkg::CRC_RESIDUE)
                               && !rx_pcb[typeb_pkg::PCB_CID]
                               && !((next_rx_type == typeb_pkg::TYPE_I)
                                    && rx_pcb[typeb_pkg::PCB_NAD])
                               && !((next_rx_type == typeb_pkg::TYPE_R)
                                    && (rx_count != 9'(typeb_pkg::MIN_BLOCK)));
               end
            end
         end
         default: begin
            next_rx_state = typeb_pkg::RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_state    <= typeb_pkg::RX_IDLE;
         rx_cnt      <= 12'h000;
         rx_bitn     <= 4'h0;
         rx_shift    <= 8'h00;
         rx_count    <= 9'h000;
         rx_crc      <= typeb_pkg::CRC_INIT;
         rx_big      <= 1'b0;
         rx_pcb      <= 8'h00;
         rx_done     <= 1'b0;
         rx_ok       <= 1'b0;
         rx_len      <= 9'h000;
         rx_type     <= 2'h0;
         rx_chaining <= 1'b0;
         rx_deselect <= 1'b0;
      end else if (ce) begin
         rx_state    <= next_rx_state;
         rx_cnt      <= next_rx_cnt;
         rx_bitn     <= next_rx_bitn;
         rx_shift    <= next_rx_shift;
         rx_count    <= next_rx_count;
         rx_crc      <= next_rx_crc;
         rx_big      <= next_rx_big;
         rx_pcb      <= next_rx_pcb;
         rx_done     <= next_rx_done;
         rx_ok       <= next_rx_ok;
         rx_len      <= next_rx_len;
         rx_type     <= next_rx_type;
         rx_chaining <= next_rx_chaining;
         rx_deselect <= next_rx_deselect;
      end
   end

   // The buffer has no reset; only bytes below rx_len are meaningful.
   always_ff @(posedge clock) begin
      if (ce) begin
         if (rx_we) begin
            rx_mem[rx_count[7:0]] <= rx_shift;
         end
         rd_data <= rx_mem[rd_addr];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Transmit side. The source may pause between bytes; the line then idles high.
   typeb_pkg::tx_state_t tx_state, next_tx_state;
   logic [11:0] tx_cnt, next_tx_cnt;
   logic [3:0]  tx_etu, next_tx_etu;
   logic [9:0]  tx_shift, next_tx_shift;
   logic [1:0]  tx_sel, next_tx_sel;
   logic [8:0]  tx_count, next_tx_count;
   logic [15:0] tx_crc, next_tx_crc;
   logic        tx_line, next_tx_line;
   logic        next_tx_ready, next_tx_err, next_tx_busy;
   logic [11:0] sub_cnt;
   logic        sub_clk;
   logic        take;

   always_comb begin
      next_tx_state = tx_state;
      next_tx_cnt   = tx_cnt;
      next_tx_etu   = tx_etu;
      next_tx_shift = tx_shift;
      next_tx_sel   = tx_sel;
      next_tx_count = tx_count;
      next_tx_crc   = tx_crc;
      next_tx_line  = tx_line;
      next_tx_ready = 1'b0;
      next_tx_err   = 1'b0;
      take          = 1'b0;
      unique case (tx_state)
         typeb_pkg::TX_IDLE: begin
            next_tx_line = 1'b1;
            if (tx_start) begin
               next_tx_state = typeb_pkg::TX_PCB;
            end
         end
         typeb_pkg::TX_PCB: begin
            if (tx_valid) begin
               next_tx_ready = 1'b1;
               if (tx_data[typeb_pkg::PCB_TYPE_HI:typeb_pkg::PCB_SFN_LO]
                   == {typeb_pkg::TYPE_S, typeb_pkg::S_WTX}) begin
                  next_tx_state = typeb_pkg::TX_IDLE;
                  next_tx_err   = 1'b1;
               end else begin
                  next_tx_state = typeb_pkg::TX_SOF;
                  next_tx_shift = {1'b1, tx_data & typeb_pkg::PCB_STRIP, 1'b0};
                  next_tx_crc   = crc_b(typeb_pkg::CRC_INIT, tx_data & typeb_pkg::PCB_STRIP);
                  next_tx_sel   = tx_last ? 2'h1 : 2'h0;
                  next_tx_count = 9'h001;
                  next_tx_cnt   = etu - 12'h001;
                  next_tx_etu   = 4'h0;
                  next_tx_line  = 1'b0;
               end
            end
         end
         typeb_pkg::TX_SOF: begin
            if (tx_cnt != 12'h000) begin
               next_tx_cnt = tx_cnt - 12'h001;
            end else begin
               next_tx_cnt  = etu - 12'h001;
               next_tx_etu  = tx_etu + 4'h1;
               next_tx_line = (next_tx_etu >= typeb_pkg::SOF_LOW_ETU);
               if (next_tx_etu == typeb_pkg::SOF_ALL_ETU) begin
                  next_tx_state = typeb_pkg::TX_CHAR;
                  next_tx_etu   = 4'h0;
                  next_tx_line  = tx_shift[0];
               end
            end
         end
         typeb_pkg::TX_CHAR: begin
            if (tx_cnt != 12'h000) begin
               next_tx_cnt = tx_cnt - 12'h001;
            end else if (tx_etu + 4'h1 < typeb_pkg::CHAR_BITS) begin
               next_tx_cnt   = etu - 12'h001;
               next_tx_etu   = tx_etu + 4'h1;
               next_tx_shift = tx_shift >> 1;
               next_tx_line  = next_tx_shift[0];
            end else if (tx_sel == 2'h0 && !tx_valid) begin
               next_tx_line = 1'b1; // Extra guard time while the source stalls.
            end else begin
               next_tx_cnt  = etu - 12'h001;
               next_tx_etu  = 4'h0;
               if (tx_sel == 2'h0) begin
                  take          = 1'b1;
                  next_tx_ready = 1'b1;
                  next_tx_count = tx_count + 9'h001;
                  next_tx_crc   = crc_b(tx_crc, tx_data);
                  next_tx_shift = {1'b1, tx_data, 1'b0};
                  if (tx_last || tx_count == 9'(typeb_pkg::MAX_INF)) begin
                     next_tx_sel = 2'h1;
                     next_tx_err = !tx_last;
                  end
               end else if (tx_sel == 2'h1) begin
                  next_tx_shift = {1'b1, ~tx_crc[7:0], 1'b0};
                  next_tx_sel   = 2'h2;
               end else if (tx_sel == 2'h2) begin
                  next_tx_shift = {1'b1, ~tx_crc[15:8], 1'b0};
                  next_tx_sel   = 2'h3;
               end else begin
                  next_tx_state = typeb_pkg::TX_EOF;
                  next_tx_shift = 10'h000;
               end
               next_tx_line = next_tx_shift[0];
            end
         end
         typeb_pkg::TX_EOF: begin
            if (tx_cnt != 12'h000) begin
               next_tx_cnt = tx_cnt - 12'h001;
            end else begin
               next_tx_cnt = etu - 12'h001;
               next_tx_etu = tx_etu + 4'h1;
               if (next_tx_etu == typeb_pkg::EOF_LOW_ETU) begin
                  next_tx_state = typeb_pkg::TX_IDLE;
                  next_tx_line  = 1'b1;
               end
            end
         end
         default: begin
            next_tx_state = typeb_pkg::TX_IDLE;
         end
      endcase
      next_tx_busy = (next_tx_state != typeb_pkg::TX_IDLE);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_state <= typeb_pkg::TX_IDLE;
         tx_cnt   <= 12'h000;
         tx_etu   <= 4'h0;
         tx_shift <= 10'h3ff;
         tx_sel   <= 2'h0;
         tx_count <= 9'h000;
         tx_crc   <= typeb_pkg::CRC_INIT;
         tx_line  <= 1'b1;
         tx_ready <= 1'b0;
         tx_err   <= 1'b0;
         tx_busy  <= 1'b0;
         sub_cnt  <= 12'h000;
         sub_clk  <= 1'b0;
         tx_mod   <= 1'b0;
      end else if (ce) begin
         tx_state <= next_tx_state;
         tx_cnt   <= next_tx_cnt;
         tx_etu   <= next_tx_etu;
         tx_shift <= next_tx_shift;
         tx_sel   <= next_tx_sel;
         tx_count <= next_tx_count;
         tx_crc   <= next_tx_crc;
         tx_line  <= next_tx_line;
         tx_ready <= next_tx_ready;
         tx_err   <= next_tx_err;
         tx_busy  <= next_tx_busy;
         sub_cnt  <= (sub_cnt == typeb_pkg::SUB_HALF - 12'h001) ? 12'h000 : sub_cnt + 12'h001;
         sub_clk  <= (sub_cnt == typeb_pkg::SUB_HALF - 12'h001) ? ~sub_clk : sub_clk;
         // Phase of the subcarrier follows the line level; silent outside frames.
         tx_mod   <= (tx_state != typeb_pkg::TX_IDLE && tx_state != typeb_pkg::TX_PCB)
                     && (sub_clk ^ ~tx_line);
      end
   end
endmodule

// File: logic/typeb_pkg.sv
// Constants, field layout and state codes for the Type B contactless framer.
// Assumes a 25 MHz system clock and demodulated, clock-synchronous link levels.
// What this block does
// - ASK NRZ in, BPSK subcarrier out, two rates.
// - LSB first, start, eight data, stop, no parity.
// - Every frame has start and end markers.
// - Data field at most 256 bytes, fully buffered.
// - Block is control byte, information, two CRC bytes.
// - Information field holds 0 to 253 bytes.
// - First byte is decoded as protocol control.
// - Device never adds identifier or address fields.
// - Information, receive-ready and supervisory block types exist.
// - Deselect supported; wait extension never issued.
// - Chaining supported; frame size at least 64 bytes.
package typeb_pkg;
   localparam int CLOCK_KHZ  = 25000;
   localparam int FC_KHZ     = 13560;
   localparam int SUB_KHZ    = 848;
   localparam int ETU_FC_106 = 128;
   localparam int ETU_FC_212 = 64;
   localparam logic [11:0] ETU_106  = 12'(CLOCK_KHZ * ETU_FC_106 / FC_KHZ);
   localparam logic [11:0] ETU_212  = 12'(CLOCK_KHZ * ETU_FC_212 / FC_KHZ);
   localparam logic [11:0] SUB_HALF = 12'(CLOCK_KHZ / (2 * SUB_KHZ));
   localparam logic [3:0] SOF_LOW_ETU  = 4'ha;
   localparam logic [3:0] SOF_ALL_ETU  = 4'hc;
   localparam logic [3:0] EOF_LOW_ETU  = 4'ha;
   localparam logic [3:0] CHAR_BITS    = 4'ha;
   localparam logic [3:0] STOP_BIT     = 4'h9;
   localparam int MAX_FIELD = 256;
   localparam int MIN_FRAME = 64;
   localparam int MAX_INF   = 253;
   localparam int MIN_BLOCK = 3;
   localparam logic [15:0] CRC_INIT    = 16'hffff;
   localparam logic [15:0] CRC_POLY    = 16'h8408;
   localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
   localparam int PCB_TYPE_HI = 7;
   localparam int PCB_TYPE_LO = 6;
   localparam int PCB_SFN_HI  = 5;
   localparam int PCB_SFN_LO  = 4;
   localparam int PCB_CHAIN   = 4;
   localparam int PCB_CID     = 3;
   localparam int PCB_NAD     = 2;
   localparam logic [1:0] TYPE_I     = 2'h0;
   localparam logic [1:0] TYPE_R     = 2'h2;
   localparam logic [1:0] TYPE_S     = 2'h3;
   localparam logic [1:0] S_DESELECT = 2'h0;
   localparam logic [1:0] S_WTX      = 2'h3;
   localparam logic [7:0] PCB_STRIP  = 8'hf3;
   typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_WAIT = 2'h1, RX_BITS = 2'h3} rx_state_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'h0, TX_PCB = 3'h1, TX_SOF = 3'h3, TX_CHAR = 3'h7, TX_EOF = 3'h6
   } tx_state_t;
endpackage

// File: tb/typeb_framer_chk.sv
// Checker for the Type B framer, seeing only the top module's ports.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ns
module typeb_framer_chk #(
   parameter int FRAME_SIZE = typeb_pkg::MAX_FIELD
) (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       rx_done,
   input wire logic       rx_ok,
   input wire logic [8:0] rx_len,
   input wire logic [1:0] rx_type,
   input wire logic       rx_chaining,
   input wire logic       rx_deselect,
   input wire logic       tx_ready,
   input wire logic       tx_busy,
   input wire logic       tx_err,
   input wire logic       tx_mod
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   a_done_pulse: assert property (rx_done |=> !rx_done)
      else $error("frame end pulse lasted more than one cycle");
   a_ok_held: assert property (!rx_done |-> $stable(rx_ok))
      else $error("block verdict changed without a frame end");
   a_len_held: assert property (!rx_done |-> $stable(rx_len))
      else $error("stored length changed without a frame end");
   a_len_bound: assert property (rx_len <= FRAME_SIZE)
      else $error("stored length above the buffer size");
   a_ok_size: assert property (rx_done && rx_ok |->
      rx_len >= typeb_pkg::MIN_BLOCK && rx_len <= typeb_pkg::MAX_INF + 3)
      else $error("legal block with impossible length");
   a_rblock_len: assert property (rx_done && rx_ok && rx_type == typeb_pkg::TYPE_R
      |-> rx_len == 3) else $error("legal receive-ready block not three bytes");
   a_desel_type: assert property (rx_deselect |-> rx_type == typeb_pkg::TYPE_S)
      else $error("deselect flagged on a non-supervisory block");
   a_chain_type: assert property (rx_chaining |-> rx_type == typeb_pkg::TYPE_I)
      else $error("chaining flagged on a non-information block");
   a_ready_gap: assert property (tx_ready && tx_busy |=> !tx_ready [*8])
      else $error("two bytes taken within one character");
   a_err_pulse: assert property (tx_err |=> !tx_err)
      else $error("refusal pulse lasted more than one cycle");
   a_mod_quiet: assert property (!tx_busy && !$past(tx_busy) |-> !tx_mod)
      else $error("modulation outside a frame");
   c_good: cover property (rx_done && rx_ok);
   c_desel: cover property (rx_done && rx_deselect);
   c_refuse: cover property (tx_err);
endmodule

// File: tb/typeb_reader_model.sv
// Reader model: sends NRZ frames on the demodulated ASK level.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ns
module typeb_reader_model (
   input  wire logic clock,
   input  wire logic rate_212,
   output logic      rx_level
);
   int unsigned etu;
   initial rx_level = 1'b1;
   always_comb etu = rate_212 ? int'(typeb_pkg::ETU_212) : int'(typeb_pkg::ETU_106);
   task automatic hold(input logic level, input int unsigned n);
      rx_level <= level;
      repeat (n * etu) @(posedge clock);
   endtask
   // Unmodulated carrier is the idle level, so the line rests high between frames.
   task automatic send_frame(input logic [7:0] bytes[$]);
      hold(1'b0, 10);
      hold(1'b1, 2);
      foreach (bytes[i]) begin
         hold(1'b0, 1);
         for (int b = 0; b < 8; b++) hold(bytes[i][b], 1);
         hold(1'b1, 1);
      end
      hold(1'b0, 10);
      hold(1'b1, 3);
   endtask
endmodule

// File: tb/testbench.sv
// Testbench for the Type B framer with a reader model on the receive side.
// Assumes the 25 MHz clock and the design's package constants.
`timescale 1ns/1ns
module testbench;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       ce = 1'b1;
   logic       rate_212 = 1'b1;
   logic       rx_level;
   logic [7:0] rd_addr = 8'h00;
   logic       tx_start = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic       tx_valid = 1'b0;
   logic       tx_last = 1'b0;
   logic [7:0] rd_data;
   logic       rx_done, rx_ok, rx_chaining, rx_deselect;
   logic [8:0] rx_len;
   logic [1:0] rx_type;
   logic       tx_ready, tx_busy, tx_err, tx_mod;
   int         miscompares = 0, checked = 0, seed = 89;
   int         cycles = 0, dones = 0, errs = 0, mods = 0;
   always #20 clock = ~clock;
   typeb_contactless_framer dut_u (.clock(clock), .rst(rst), .ce(ce), .rate_212(rate_212),
      .rx_level(rx_level), .rd_addr(rd_addr), .tx_start(tx_start), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_last(tx_last), .rd_data(rd_data), .rx_done(rx_done),
      .rx_ok(rx_ok), .rx_len(rx_len), .rx_type(rx_type), .rx_chaining(rx_chaining),
      .rx_deselect(rx_deselect), .tx_ready(tx_ready), .tx_busy(tx_busy), .tx_err(tx_err),
      .tx_mod(tx_mod));
   typeb_reader_model reader_u (.clock(clock), .rate_212(rate_212), .rx_level(rx_level));
   ////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (miscompares == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // The run is about 67000 cycles, so this ceiling only trips on a hang.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (rx_done === 1'b1) dones <= dones + 1;
      if (tx_err === 1'b1) errs <= errs + 1;
      if (tx_mod === 1'b1) mods <= mods + 1;
      if (cycles == 90000) begin
         miscompares++;
         print_verdict();
      end
   end
   function automatic logic [15:0] crc_b(input logic [7:0] bytes[$]);
      logic [15:0] c;
      c = typeb_pkg::CRC_INIT;
      foreach (bytes[i]) begin
         c = c ^ {8'h00, bytes[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ typeb_pkg::CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction
   task automatic rx_frame(input logic [7:0] pcb, input int n_inf, input logic bad,
                           input logic exp_ok);
      logic [7:0]  blk[$];
      logic [15:0] c;
      int          d0;
      blk = {pcb};
      repeat (n_inf) blk.push_back(8'($random(seed)));
      c = crc_b(blk) ^ {15'h0000, bad};
      blk.push_back(c[7:0]);
      blk.push_back(c[15:8]);
      d0 = dones;
      @(posedge clock);
      reader_u.send_frame(blk);
      check("rx_done count", 16'(d0 + 1), 16'(dones));
      check("rx_ok", 16'(exp_ok), 16'(rx_ok));
      check("rx_len", 16'(blk.size()), 16'(rx_len));
      if (exp_ok) begin
         check("rx_type", 16'(pcb[7:6]), 16'(rx_type));
         check("rx_chaining", 16'(pcb[7:6] == typeb_pkg::TYPE_I && pcb[4]),
               16'(rx_chaining));
         check("rx_deselect", 16'(pcb[7:6] == typeb_pkg::TYPE_S && pcb[5:4] == 2'h0),
               16'(rx_deselect));
      end
      foreach (blk[i]) begin
         @(posedge clock) rd_addr <= 8'(i);
         @(posedge clock);
         @(negedge clock);
         check("rd_data", 16'(blk[i]), 16'(rd_data));
      end
   endtask
   task automatic send_byte(input logic [7:0] d, input logic last);
      int n;
      @(posedge clock) begin
         tx_data <= d;
         tx_valid <= 1'b1;
         tx_last <= last;
      end
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (tx_ready !== 1'b1 && tx_err !== 1'b1 && n < 20000);
      @(posedge clock) tx_valid <= 1'b0;
      check("byte taken", 16'h0001, 16'(n < 20000));
   endtask
   task automatic tx_frame(input logic [7:0] pcb, input logic wtx);
      int e0, m0, n;
      e0 = errs;
      m0 = mods;
      @(posedge clock) tx_start <= 1'b1;
      @(posedge clock) tx_start <= 1'b0;
      send_byte(pcb, wtx);
      if (!wtx) send_byte(8'($random(seed)), 1'b1);
      for (n = 0; n < 20000 && tx_busy !== 1'b0; n++) @(posedge clock);
      repeat (2) @(posedge clock);
      check("tx_busy", 16'h0000, 16'(tx_busy));
      check("tx_err count", 16'(e0 + wtx), 16'(errs));
      check("tx_mod active", 16'(!wtx), 16'(mods > m0));
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      rx_frame(8'h02, 2, 1'b0, 1'b1);
      rx_frame(8'h03, 1, 1'b1, 1'b0);
      rx_frame(8'h0a, 1, 1'b0, 1'b0);
      rx_frame(8'h12, 2, 1'b0, 1'b1);
      rx_frame(8'hc2, 0, 1'b0, 1'b1);
      rx_frame(8'ha2, 1, 1'b0, 1'b0);
      @(posedge clock) rate_212 <= 1'b0;
      rx_frame(8'ha2, 0, 1'b0, 1'b1);
      @(posedge clock) rate_212 <= 1'b1;
      tx_frame(8'h0a, 1'b0);
      tx_frame(8'hf2, 1'b1);
      print_verdict();
   end
endmodule
bind typeb_contactless_framer typeb_framer_chk #(.FRAME_SIZE(FRAME_SIZE)) chk_u (
   .clock(clock), .rst(rst), .rx_done(rx_done), .rx_ok(rx_ok), .rx_len(rx_len),
   .rx_type(rx_type), .rx_chaining(rx_chaining), .rx_deselect(rx_deselect),
   .tx_ready(tx_ready), .tx_busy(tx_busy), .tx_err(tx_err), .tx_mod(tx_mod));
